//--- include/pwm_params.svh
// constants for the duty compare and dead-time stage
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH

// widths
`define PWM_DUTY_W 16
`define PWM_CNT_W 15
`define PWM_DT_W 6
`define PWM_PRE_W 3
`define PWM_PAIRS 3

// reset values
`define PWM_DUTY_RST 16'h0000
`define PWM_DT_CNT_RST 6'h00
`define PWM_PRE_RST 3'h0

// time base mode codes
`define PWM_MODE_FREE 2'h0
`define PWM_MODE_SINGLE 2'h1
`define PWM_MODE_UPDOWN 2'h2
`define PWM_MODE_UPDOWN_DBL 2'h3

// dead-time prescale codes and the matching tick masks (1, 2, 4, 8 cycles)
`define PWM_DTPS_1 2'h0
`define PWM_DTPS_2 2'h1
`define PWM_DTPS_4 2'h2
`define PWM_DTPS_8 2'h3
`define PWM_DTMASK_1 3'h0
`define PWM_DTMASK_2 3'h1
`define PWM_DTMASK_4 3'h3
`define PWM_DTMASK_8 3'h7

`endif

//--- include/pwm_pkg.sv
// types shared by the duty compare and dead-time stage
package pwm_pkg;

  typedef enum logic [1:0] {
    TB_FREE = 2'h0,
    TB_SINGLE = 2'h1,
    TB_UPDOWN = 2'h2,
    TB_UPDOWN_DBL = 2'h3
  } tb_mode_e;

  typedef enum logic [1:0] {
    DT_IDLE = 2'h0,
    DT_WAIT_HIGH = 2'h1,
    DT_WAIT_LOW = 2'h2
  } dt_state_e;

  typedef struct packed {
    logic comp;
  } compare_s;

  typedef struct packed {
    dt_state_e state;
    logic [5:0] count;
    logic [2:0] pre;
    logic [2:0] pre_mask;
    logic comp_q;
    logic high;
    logic low;
    logic busy;
  } deadtime_s;

  typedef struct packed {
    logic [2:0][15:0] buffer;
    logic [2:0][15:0] active;
    logic [2:0] imm_eval;
    logic reload_pulse;
  } duty_top_s;

endpackage

//--- core/duty_compare_unit.sv
// one duty comparison unit: edge- or center-aligned compare output
`timescale 1ns/1ps
`include "pwm_params.svh"

module duty_compare_unit #(
  parameter int DUTY_W = `PWM_DUTY_W,
  parameter int CNT_W = `PWM_CNT_W
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic center, // up/down time base selected
  input wire logic [DUTY_W-1:0] fine_count, // count with half-count phase as lsb
  input wire logic count_down, // time base counting down
  input wire logic [CNT_W-1:0] period_value, // active period
  input wire logic [DUTY_W-1:0] duty_active, // active compare value
  input wire logic imm_eval, // re-evaluate after an immediate update
  output logic comp_out // compare output, active high
);

  pwm_pkg::compare_s s_r;
  pwm_pkg::compare_s s_nxt;
  logic [DUTY_W-1:0] period_fine;

  assign period_fine = {period_value, 1'b0};
  assign comp_out = s_r.comp;

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (!center) begin
      // active from zero up to the match, lsb gives the half-count edge
      s_nxt.comp = (fine_count < duty_active);
    end else if (duty_active == `PWM_DUTY_RST) begin
      s_nxt.comp = 1'b0;
    end else if (duty_active >= period_fine) begin
      s_nxt.comp = 1'b1;
    end else if (imm_eval) begin
      s_nxt.comp = (fine_count < duty_active);
    end else if (fine_count == duty_active) begin
      // direction flag high means down-counting
      s_nxt.comp = count_down;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

//--- core/deadtime_unit.sv
// dead-time insertion for one output pair
`timescale 1ns/1ps
`include "pwm_params.svh"

module deadtime_unit #(
  parameter int DT_W = `PWM_DT_W
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic comp, // duty compare output
  input wire logic independent, // pair runs independently
  input wire logic cfg_wr, // dead-time configuration written
  input wire logic [DT_W-1:0] dt_a_count, // dead time a count
  input wire logic [DT_W-1:0] dt_b_count, // dead time b count
  input wire logic [1:0] dt_a_prescale, // dead time a unit
  input wire logic [1:0] dt_b_prescale, // dead time b unit
  input wire logic active_sel, // dead time at active edge: 0 a, 1 b
  input wire logic inactive_sel, // dead time at inactive edge: 0 a, 1 b
  output logic high_out, // high-side drive
  output logic low_out, // low-side drive
  output logic busy // dead time in progress
);

  pwm_pkg::deadtime_s s_r;
  pwm_pkg::deadtime_s s_nxt;

  assign high_out = s_r.high;
  assign low_out = s_r.low;
  assign busy = s_r.busy;

  function automatic logic [2:0] mask_of(input logic [1:0] ps);
    case (ps)
      `PWM_DTPS_1: mask_of = `PWM_DTMASK_1;
      `PWM_DTPS_2: mask_of = `PWM_DTMASK_2;
      `PWM_DTPS_4: mask_of = `PWM_DTMASK_4;
      default: mask_of = `PWM_DTMASK_8;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // edge detect, prescaler and down counter
  // ----------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic tick;
    logic [DT_W-1:0] load;
    rise = 1'b0;
    fall = 1'b0;
    tick = 1'b0;
    load = '0;
    s_nxt = s_r;
    s_nxt.comp_q = comp;
    rise = comp & ~s_r.comp_q;
    fall = ~comp & s_r.comp_q;
    tick = ((s_r.pre & s_r.pre_mask) == s_r.pre_mask);
    s_nxt.pre = s_r.pre + 3'h1;
    if (cfg_wr) begin
      s_nxt.pre = `PWM_PRE_RST;
    end
    if (independent) begin
      // no dead time, both sides follow the one compare output
      s_nxt.state = pwm_pkg::DT_IDLE;
      s_nxt.count = `PWM_DT_CNT_RST;
      s_nxt.high = comp;
      s_nxt.low = comp;
    end else if (rise || fall) begin
      load = (rise ? active_sel : inactive_sel) ? dt_b_count : dt_a_count;
      s_nxt.pre_mask = mask_of((rise ? active_sel : inactive_sel) ?
                               dt_b_prescale : dt_a_prescale);
      s_nxt.pre = `PWM_PRE_RST;
      s_nxt.count = load;
      s_nxt.high = 1'b0;
      s_nxt.low = 1'b0;
      if (load == `PWM_DT_CNT_RST) begin
        s_nxt.state = pwm_pkg::DT_IDLE;
        s_nxt.high = comp;
        s_nxt.low = ~comp;
      end else begin
        s_nxt.state = rise ? pwm_pkg::DT_WAIT_HIGH : pwm_pkg::DT_WAIT_LOW;
      end
    end else begin
      case (s_r.state)
        pwm_pkg::DT_IDLE: begin
          s_nxt.high = comp;
          s_nxt.low = ~comp;
        end
        pwm_pkg::DT_WAIT_HIGH, pwm_pkg::DT_WAIT_LOW: begin
          if (tick) begin
            s_nxt.count = s_r.count - 6'h01;
            if (s_r.count == 6'h01) begin
              s_nxt.state = pwm_pkg::DT_IDLE;
              s_nxt.high = (s_r.state == pwm_pkg::DT_WAIT_HIGH);
              s_nxt.low = (s_r.state == pwm_pkg::DT_WAIT_LOW);
            end
          end
        end
        default: begin
          s_nxt.state = pwm_pkg::DT_IDLE;
        end
      endcase
    end
    s_nxt.busy = (s_nxt.state != pwm_pkg::DT_IDLE);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

//--- core/pwm_duty_compare_deadtime.sv
// duty compare and dead-time output stage for three pwm output pairs
// ------------------------------------------------------------------
// Summary of operation
// - up/down time base gives center-aligned output, other modes edge-aligned.
// - up/down: count equals duty while counting down sets output active.
// - up/down: count equals duty while counting up sets output inactive.
// - center-aligned: duty of zero keeps output inactive all period.
// - center-aligned: duty equal to period keeps output active all period.
// - three software-written 16-bit duty registers, one per unit.
// - duty lsb moves the edge by half a count, doubling resolution.
// - each duty has a visible buffer and a separate active compare value.
// - edge-aligned: active value reloads on period match and counter reset.
// - edge-aligned: continuous reload while time base stopped and hold clear.
// - single-update up/down: reload at zero turning upward, or when stopped.
// - double-update up/down: reload at zero and period match, or when stopped.
// - immediate update set: a duty write reaches the active value at once.
// - immediate update shortens, lengthens, or starts the pulse by new value.
// - units one, two, three drive pairs one, two, three as high/low.
// - pair is complementary with mode bit clear; reset defaults complementary.
// - two programmable dead times, per edge direction or per pair.
// - each pair has a 6-bit down counter fed by compare edge detectors.
// - per pair, one bit picks active-edge dead time, one inactive-edge.
// - each dead time has a 2-bit prescaler of 1, 2, 4, 8 cycles.
// - prescalers clear on counter load, configuration write and reset.
// - mode bit set: independent pair, no dead time, one unit drives both.
// - direction flag is set while counting down, clear while counting up.
// - update hold set blocks buffer to active duty transfers.
// ------------------------------------------------------------------
`timescale 1ns/1ps
`include "pwm_params.svh"

module pwm_duty_compare_deadtime #(
  parameter int DUTY_W = `PWM_DUTY_W,
  parameter int CNT_W = `PWM_CNT_W,
  parameter int DT_W = `PWM_DT_W,
  parameter int PAIRS = `PWM_PAIRS
) (
  input wire logic clk_sys, // system clock, 100 mhz
  input wire logic rst, // async reset, active high
  // time base
  input wire logic [CNT_W-1:0] timebase_count, // time base count
  input wire logic count_down_flag, // 1 while counting down
  input wire logic half_count_phase, // 1 in second half of a count
  input wire logic [CNT_W-1:0] period_value, // active period
  input wire logic timebase_run, // time base enabled
  input wire logic [1:0] timebase_mode, // time base mode code
  // update control
  input wire logic update_hold, // block buffer transfers
  input wire logic immediate_update_en, // duty writes act at once
  input wire logic [PAIRS-1:0] pair_independent_sel, // 1: pair independent
  // duty writes
  input wire logic [PAIRS-1:0] duty_wr_en, // one-cycle write strobe per unit
  input wire logic [DUTY_W-1:0] duty_wr_data, // duty write data
  // dead-time configuration
  input wire logic deadtime_config_one_wr, // strobe: values or prescales written
  input wire logic deadtime_config_two_wr, // strobe: selection bits written
  input wire logic [1:0] deadtime_a_prescale, // dead time a unit
  input wire logic [1:0] deadtime_b_prescale, // dead time b unit
  input wire logic [DT_W-1:0] deadtime_a_count, // dead time a count
  input wire logic [DT_W-1:0] deadtime_b_count, // dead time b count
  input wire logic pair1_active_edge_sel, // pair 1 active edge: 0 a, 1 b
  input wire logic pair1_inactive_edge_sel, // pair 1 inactive edge: 0 a, 1 b
  input wire logic pair2_active_edge_sel, // pair 2 active edge: 0 a, 1 b
  input wire logic pair2_inactive_edge_sel, // pair 2 inactive edge: 0 a, 1 b
  input wire logic pair3_active_edge_sel, // pair 3 active edge: 0 a, 1 b
  input wire logic pair3_inactive_edge_sel, // pair 3 inactive edge: 0 a, 1 b
  // outputs
  output logic [PAIRS-1:0] high_output, // high-side drives, active high
  output logic [PAIRS-1:0] low_output, // low-side drives, active high
  output logic [PAIRS-1:0] compare_state, // raw compare outputs
  output logic [PAIRS-1:0] deadtime_busy, // dead time running per pair
  output logic [DUTY_W-1:0] duty_value_one, // duty buffer one readback
  output logic [DUTY_W-1:0] duty_value_two, // duty buffer two readback
  output logic [DUTY_W-1:0] duty_value_three, // duty buffer three readback
  output logic [DUTY_W-1:0] active_duty_one, // active compare one
  output logic [DUTY_W-1:0] active_duty_two, // active compare two
  output logic [DUTY_W-1:0] active_duty_three, // active compare three
  output logic duty_reload_pulse // one cycle after a buffered reload
);

  // ----------------------------------------------------------------
  // state and decoded controls
  // ----------------------------------------------------------------
  pwm_pkg::duty_top_s s_r;
  pwm_pkg::duty_top_s s_nxt;
  pwm_pkg::tb_mode_e mode;
  logic center;
  logic at_zero;
  logic at_period;
  logic boundary;
  logic reload;
  logic dt_cfg_wr;
  logic [DUTY_W-1:0] fine_count;
  logic [PAIRS-1:0] comp;
  logic [PAIRS-1:0] act_sel;
  logic [PAIRS-1:0] inact_sel;

  assign mode = pwm_pkg::tb_mode_e'(timebase_mode);
  assign center = (mode == pwm_pkg::TB_UPDOWN) || (mode == pwm_pkg::TB_UPDOWN_DBL);
  assign fine_count = {timebase_count, half_count_phase};
  assign at_zero = (timebase_count == '0);
  assign at_period = (timebase_count == period_value);
  assign dt_cfg_wr = deadtime_config_one_wr | deadtime_config_two_wr;
  assign act_sel = {pair3_active_edge_sel, pair2_active_edge_sel, pair1_active_edge_sel};
  assign inact_sel = {pair3_inactive_edge_sel, pair2_inactive_edge_sel,
                      pair1_inactive_edge_sel};

  // ----------------------------------------------------------------
  // reload moments per time base mode
  // ----------------------------------------------------------------
  always_comb begin
    boundary = 1'b0;
    case (mode)
      pwm_pkg::TB_FREE, pwm_pkg::TB_SINGLE: begin
        boundary = at_period;
      end
      pwm_pkg::TB_UPDOWN: begin
        boundary = at_zero && !count_down_flag;
      end
      pwm_pkg::TB_UPDOWN_DBL: begin
        boundary = at_zero || at_period;
      end
      default: begin
        boundary = 1'b0;
      end
    endcase
  end

  // stopped time base reloads continuously in every mode; hold blocks all
  assign reload = (timebase_run ? boundary : 1'b1) &&
                  !update_hold;

  // ----------------------------------------------------------------
  // duty buffers and active compare values
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.reload_pulse = reload;
    for (int i = 0; i < PAIRS; i++) begin
      s_nxt.imm_eval[i] = 1'b0;
      if (duty_wr_en[i]) begin
        s_nxt.buffer[i] = duty_wr_data;
      end
      if (duty_wr_en[i] && immediate_update_en) begin
        // immediate writes bypass the hold and the period boundary
        s_nxt.active[i] = duty_wr_data;
        s_nxt.imm_eval[i] = 1'b1;
      end else if (reload) begin
        // a write in the reload cycle is taken along
        s_nxt.active[i] = duty_wr_en[i] ? duty_wr_data : s_r.buffer[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // compare units and dead-time pairs
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < PAIRS; g++) begin : g_pair
      duty_compare_unit #(
        .DUTY_W(DUTY_W),
        .CNT_W(CNT_W)
      ) u_cmp (
        .clk_sys(clk_sys),
        .rst(rst),
        .center(center),
        .fine_count(fine_count),
        .count_down(count_down_flag),
        .period_value(period_value),
        .duty_active(s_r.active[g]),
        .imm_eval(s_r.imm_eval[g]),
        .comp_out(comp[g])
      );

      // unit g drives pair g
      deadtime_unit #(
        .DT_W(DT_W)
      ) u_dt (
        .clk_sys(clk_sys),
        .rst(rst),
        .comp(comp[g]),
        .independent(pair_independent_sel[g]),
        .cfg_wr(dt_cfg_wr),
        .dt_a_count(deadtime_a_count),
        .dt_b_count(deadtime_b_count),
        .dt_a_prescale(deadtime_a_prescale),
        .dt_b_prescale(deadtime_b_prescale),
        .active_sel(act_sel[g]),
        .inactive_sel(inact_sel[g]),
        .high_out(high_output[g]),
        .low_out(low_output[g]),
        .busy(deadtime_busy[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  assign compare_state = comp;
  assign duty_value_one = s_r.buffer[0];
  assign duty_value_two = s_r.buffer[1];
  assign duty_value_three = s_r.buffer[2];
  assign active_duty_one = s_r.active[0];
  assign active_duty_two = s_r.active[1];
  assign active_duty_three = s_r.active[2];
  assign duty_reload_pulse = s_r.reload_pulse;

endmodule

//--- verification/pwm_duty_compare_deadtime_properties.sv
// concurrent checks on the ports of the pwm duty compare and dead-time stage
`timescale 1ns/1ps
module pwm_duty_checker #(
  parameter int DUTY_W = 16,
  parameter int CNT_W = 15,
  parameter int DT_W = 6,
  parameter int PAIRS = 3
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic [CNT_W-1:0] timebase_count, // count
  input wire logic count_down_flag, // direction
  input wire logic half_count_phase, // half phase
  input wire logic timebase_run, // run
  input wire logic [1:0] timebase_mode, // mode
  input wire logic update_hold, // hold
  input wire logic immediate_update_en, // immediate
  input wire logic [PAIRS-1:0] pair_independent_sel, // pair mode
  input wire logic [PAIRS-1:0] duty_wr_en, // write strobes
  input wire logic [DUTY_W-1:0] duty_wr_data, // write data
  input wire logic [1:0] deadtime_a_prescale, // a unit
  input wire logic [DT_W-1:0] deadtime_a_count, // a count
  input wire logic pair1_active_edge_sel, // pair 1 select
  input wire logic [PAIRS-1:0] high_output, // high sides
  input wire logic [PAIRS-1:0] low_output, // low sides
  input wire logic [PAIRS-1:0] compare_state, // compares
  input wire logic [PAIRS-1:0] deadtime_busy, // busy
  input wire logic [DUTY_W-1:0] duty_value_one, // buffer one
  input wire logic [DUTY_W-1:0] active_duty_one, // active one
  input wire logic duty_reload_pulse // reload pulse
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_NO_OVERLAP:
    assert property ((high_output & low_output & ~pair_independent_sel) == 3'h0)
    else $error("complementary pair drives both sides");
  AST_INDEP_PAIR:
    assert property (pair_independent_sel[2] && $past(pair_independent_sel[2]) |->
      high_output[2] == $past(compare_state[2]) && low_output[2] == high_output[2])
    else $error("independent pair does not follow its compare");
  AST_WRITE_BUF:
    assert property (duty_wr_en[0] |=> duty_value_one == $past(duty_wr_data))
    else $error("duty buffer missed a write");
  AST_IMM_WRITE:
    assert property (duty_wr_en[0] && immediate_update_en |=>
      active_duty_one == $past(duty_wr_data))
    else $error("immediate write missed the active duty");
  AST_HOLD:
    assert property (update_hold && !immediate_update_en |=> $stable(active_duty_one))
    else $error("active duty changed under hold");
  AST_STOPPED_LOAD:
    assert property (!timebase_run && !update_hold && !duty_wr_en[0] |=>
      active_duty_one == $past(duty_value_one) && duty_reload_pulse)
    else $error("stopped time base did not reload");
  AST_CENTER_ZERO:
    assert property (timebase_mode[1] && active_duty_one == 16'h0000 |=> !compare_state[0])
    else $error("zero duty drove the output");
  AST_DOWN_MATCH:
    assert property (timebase_mode[1] && count_down_flag && |active_duty_one &&
      !$past(duty_wr_en[0]) && {timebase_count, half_count_phase} == active_duty_one
      |=> compare_state[0])
    else $error("down-count match did not set the compare");
  AST_DEAD_WAIT:
    assert property ($rose(compare_state[0]) && !pair_independent_sel[0] &&
      !pair1_active_edge_sel && deadtime_a_prescale == 2'h0 && deadtime_a_count > 6'h01
      |=> !high_output[0] && deadtime_busy[0] ##1 !high_output[0])
    else $error("high side turned on before dead time");
  AST_EDGE_CMP:
    assert property (!timebase_mode[1] && {timebase_count, half_count_phase} < active_duty_one
      |=> compare_state[0])
    else $error("edge-aligned compare low below duty");
endmodule

bind pwm_duty_compare_deadtime pwm_duty_checker #(.DUTY_W(DUTY_W), .CNT_W(CNT_W),
  .DT_W(DT_W), .PAIRS(PAIRS)) i_chk (.clk_sys, .rst, .timebase_count, .count_down_flag,
  .half_count_phase, .timebase_run, .timebase_mode, .update_hold, .immediate_update_en,
  .pair_independent_sel, .duty_wr_en, .duty_wr_data, .deadtime_a_prescale,
  .deadtime_a_count, .pair1_active_edge_sel, .high_output, .low_output, .compare_state,
  .deadtime_busy, .duty_value_one, .active_duty_one, .duty_reload_pulse);

//--- verification/gate_driver_model.sv
// gate driver model of one complementary half-bridge
`timescale 1ns/1ps
module gate_driver_model (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic high_in, // high-side gate
  input wire logic low_in, // low-side gate
  output logic shoot, // both gates seen on
  output int gap, // idle cycles before last turn-on
  output logic gap_new, // gap just measured
  output logic gap_high // last turn-on was the high side
);
  int dead;
  logic high_q;
  logic low_q;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shoot <= 1'b0;
      dead <= 0;
      gap <= 0;
      gap_new <= 1'b0;
      gap_high <= 1'b0;
      high_q <= 1'b0;
      low_q <= 1'b0;
    end else begin
      // both transistors on shorts the supply
      if (high_in && low_in) begin
        shoot <= 1'b1;
      end
      dead <= (high_in || low_in) ? 0 : dead + 1;
      gap_new <= (high_in && !high_q) || (low_in && !low_q);
      gap_high <= high_in;
      gap <= dead;
      high_q <= high_in;
      low_q <= low_in;
    end
  end
endmodule

//--- verification/pwm_duty_compare_deadtime_tb.sv
// self-checking testbench for the pwm duty compare and dead-time stage
`timescale 1ns/1ps
module pwm_duty_compare_deadtime_tb;
  logic clk_sys, rst, dn, ph, run, hold, ie, c1wr, c2wr, rp, gchk;
  logic [14:0] cnt, per;
  logic [1:0] mode, aps, bps, shoot;
  logic [2:0] pind, wr, sa, si, hi, lo, cs, busy;
  logic [5:0] ac, bc;
  logic [15:0] wdat;
  logic [15:0] dv[3];
  logic [15:0] ad[3];
  logic gnew[2];
  logic ghigh[2];
  int gap[2];
  int m_buf[3], m_act[3], m_cmp[3], m_imm[3];
  int m_pul = 0;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  pwm_duty_compare_deadtime i_dut (
    .clk_sys, .rst, .timebase_count(cnt), .count_down_flag(dn), .half_count_phase(ph),
    .period_value(per), .timebase_run(run), .timebase_mode(mode), .update_hold(hold),
    .immediate_update_en(ie), .pair_independent_sel(pind), .duty_wr_en(wr),
    .duty_wr_data(wdat), .deadtime_config_one_wr(c1wr), .deadtime_config_two_wr(c2wr),
    .deadtime_a_prescale(aps), .deadtime_b_prescale(bps), .deadtime_a_count(ac),
    .deadtime_b_count(bc), .pair1_active_edge_sel(sa[0]), .pair1_inactive_edge_sel(si[0]),
    .pair2_active_edge_sel(sa[1]), .pair2_inactive_edge_sel(si[1]),
    .pair3_active_edge_sel(sa[2]), .pair3_inactive_edge_sel(si[2]),
    .high_output(hi), .low_output(lo), .compare_state(cs), .deadtime_busy(busy),
    .duty_value_one(dv[0]), .duty_value_two(dv[1]), .duty_value_three(dv[2]),
    .active_duty_one(ad[0]), .active_duty_two(ad[1]), .active_duty_three(ad[2]),
    .duty_reload_pulse(rp)
  );

  for (genvar p = 0; p < 2; p++) begin : g_drv
    gate_driver_model i_drv (.clk_sys, .rst, .high_in(hi[p]), .low_in(lo[p]),
      .shoot(shoot[p]), .gap(gap[p]), .gap_new(gnew[p]), .gap_high(ghigh[p]));
  end

  always #5 clk_sys = ~clk_sys;

  // ----------
  // time base and reference model
  // ----------
  always @(posedge clk_sys) begin
    #1;
    if (run && ph) begin
      cnt = (mode[1] && dn) ? cnt - 15'h0001 : (!mode[1] && cnt == per) ? 15'h0000
        : cnt + 15'h0001;
      dn = mode[1] && (dn ? cnt != 15'h0000 : cnt == per);
    end
    if (run) ph = !ph;
  end

  always @(posedge clk_sys) begin : ref_model
    int f;
    logic rl;
    f = int'(cnt) * 2 + int'(ph);
    rl = !hold && (!run || (mode == 2'h3 ? (cnt == 15'h0000 || cnt == per)
      : mode == 2'h2 ? (cnt == 15'h0000 && !dn) : cnt == per));
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        {m_buf[i], m_act[i], m_cmp[i], m_imm[i]} = 128'h0;
      end else begin
        if (!mode[1]) m_cmp[i] = f < m_act[i];
        else if (m_act[i] == 0) m_cmp[i] = 0;
        else if (m_act[i] >= 2 * per) m_cmp[i] = 1;
        else if (m_imm[i]) m_cmp[i] = f < m_act[i];
        else if (f == m_act[i]) m_cmp[i] = dn;
        m_imm[i] = wr[i] && ie;
        if (wr[i] && ie) m_act[i] = wdat;
        else if (rl) m_act[i] = wr[i] ? wdat : m_buf[i];
        if (wr[i]) m_buf[i] = wdat;
      end
    end
    m_pul = !rst && rl;
  end

  // ----------
  // checks
  // ----------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  function automatic int dt_len(input logic b);
    return b ? int'(bc) << bps : int'(ac) << aps;
  endfunction

  always @(negedge clk_sys) begin
    if (!rst) begin
      for (int i = 0; i < 3; i++) begin
        chk("duty buffer", m_buf[i], dv[i]);
        chk("active duty", m_act[i], ad[i]);
        chk("compare", m_cmp[i], cs[i]);
      end
      chk("reload pulse", m_pul, rp);
      for (int p = 0; p < 2; p++) begin
        if (gchk && gnew[p])
          chk("dead gap", dt_len(ghigh[p] ? sa[p] : si[p]), gap[p]);
        chk("shoot through", 0, shoot[p]);
      end
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr_duty(input int u, input logic [15:0] d);
    wr = 3'h1 << u;
    wdat = d;
    step(1);
    wr = 3'h0;
    step(1);
  endtask

  // ----------
  // scenarios
  // ----------
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {dn, ph, run, hold, ie, c1wr, c2wr, gchk} = 8'h00;
    {cnt, wr, wdat, mode, aps, bps, ac, bc, sa, si} = 58'h0;
    per = 15'h000A;
    pind = 3'h4;
    void'($urandom(32'h7BCDA7D1));
    step(10);
    rst = 1'b0;
    step(2);
    chk("low after reset", 2'h3, lo[1:0]);
    chk("high after reset", 3'h0, hi);
    for (int i = 0; i < 6; i++) begin
      hold = (i > 2);
      wr_duty(i % 3, 16'($urandom));
    end
    step(4);
    hold = 1'b0;
    run = 1'b1;
    for (int m = 0; m < 4; m++) begin
      mode = 2'(m);
      wr_duty(0, 16'($urandom_range(2 * per + 1)));
      wr_duty(1, 16'h0000);
      wr_duty(2, {per, 1'b0});
      step(100);
      wr_duty(0, 16'($urandom_range(2 * per + 1)));
      step(100);
    end
    mode = 2'h2;
    ie = 1'b1;
    for (int i = 0; i < 24; i++) begin
      hold = i[0];
      wr_duty(i % 3, 16'($urandom_range(2 * per + 1)));
      step($urandom_range(1, 12));
    end
    {ie, hold, run} = 3'h0;
    per = 15'h0028;
    for (int ps = 0; ps < 4; ps++) begin
      {aps, bps} = {2'(ps), 2'(3 - ps)};
      ac = 6'($urandom_range(2, 6));
      bc = 6'($urandom_range(1, 6));
      sa = (ps == 0) ? 3'h0 : 3'($urandom);
      si = 3'($urandom);
      {c1wr, c2wr} = 2'h3;
      step(1);
      {c1wr, c2wr} = 2'h0;
      wr_duty(0, {1'b0, per});
      wr_duty(1, {1'b0, per});
      {run, gchk} = 2'h3;
      step(400);
      {run, gchk} = 2'h0;
      // let a running dead time end before the configuration changes
      step(50);
    end
    wrap_up();
  end
endmodule
